// ===== logic/irs_top.sv
/*
 * Interrupt flag, interrupt mask and reset cause logic with reset pin stretch.
 * Assumes an internal register port already deserialised from the serial
 * peripheral, asynchronous analog condition levels, and an open-drain reset pin.
 */
// Behaviour
// - Low supply flag sets on condition; write one clears only once condition gone.
// - Over supply flag sets on condition; write one clears only once condition gone.
// - Read-only stage fail flag is the OR of all power stage fault flags.
// - Each flag requests an interrupt only while its enable bit is one.
// - Reset clears all enable bits and the thermal reset disable bit.
// - Thermal reset disable bit set suppresses the high temperature reset.
// - Reset pin stays low for the stretch time after an internal cause ends.
// - Causes: overtemperature, watchdog, regulator low voltage, power-on, external pin.
// - Overtemperature resets, logs its cause, clears registers except the cause log.
// - Watchdog fault resets, logs its cause, clears registers except the cause log.
// - Regulator low voltage pulls pin low, logs cause, clears other registers.
// - Power-on clears everything, then sets the power-on cause bit and any wake source bit.
// - Power-on holds the reset pin low for the stretch time after supply good.
// - External low drive on the reset pin is logged as a pin reset.
// - Cause bits clear only by writing one or by power-on.
// - Sleep wake-up logs bus or wake input as source; write one clears.
// - Enabled events are reported as a low pulse on the interrupt line.
// - Overtemperature flag cannot be cleared by a write while the condition remains; an enabled thermal reset clears it.
`default_nettype none

module irs_top #(
	parameter int STRETCH = irs_pkg::STRETCH_CYC,
	parameter int NSTG    = irs_pkg::N_STAGES
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire irs_pkg::irs_req_t req,
	input  wire irs_pkg::irs_cond_t cond,
	input  wire logic [NSTG-1:0]   stage_fault,
	input  wire logic              rst_pin_in,
	output logic      [7:0]        rd_data,
	output logic                   rd_valid,
	output logic                   irq_b,
	output logic                   rst_pin_out,
	output logic                   rst_pin_oe_b
);

	localparam int CW = $bits(irs_pkg::irs_cond_t);
	localparam int SW = CW + NSTG + 1;
	localparam logic [SW-1:0] SYNC_INIT = {1'h1, {(SW-1){1'h0}}};
	localparam logic [irs_pkg::STRETCH_W-1:0] STRETCH_LD = irs_pkg::STRETCH_W'(STRETCH);

	function automatic logic hit(
		input logic       stb,
		input logic [7:0] a,
		input logic [7:0] t
	);
		return stb && (a == t);
	endfunction

	logic [1:0]                       rst_pipe;
	logic                             rst_sync_b;
	logic [SW-1:0]                    sync_q;
	irs_pkg::irs_cond_t               cond_s;
	logic [NSTG-1:0]                  fault_s;
	logic                             pin_s;
	logic                             ot_cause;
	logic                             int_cause;
	logic [irs_pkg::STRETCH_W-1:0]    stretch_cnt;
	logic [irs_pkg::PIN_GUARD-1:0]    drive_hist;
	logic                             drive;
	logic                             ext_low;
	logic                             soft_clr;
	logic                             por_phase;
	logic                             wake_prev;
	logic                             hall_prev;
	logic                             bus_prev;
	logic [7:0]                       ifr;
	logic                             power_stage_fail_flag;
	logic [7:0]                       interrupt_enable_mask;
	logic [7:0]                       reset_cause_log;
	logic [7:0]                       ifr_view;
	logic [7:0]                       pend;
	logic [7:0]                       pend_q;
	logic [7:0]                       next_ifr;
	logic [7:0]                       next_cause;
	logic [7:0]                       ifr_set;
	logic [7:0]                       ifr_clr;
	logic [7:0]                       cause_set;
	logic [7:0]                       cause_clr;
	logic                             wr_mask;
	logic                             wr_flags;
	logic                             wr_cause;

	////////////////////////////////////////////////////////////////////////////
	// Reset release and input synchronisers

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rst_pipe <= 2'h0;
		else
			rst_pipe <= {rst_pipe[0], 1'h1};
	end

	assign rst_sync_b = rst_pipe[1];

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_sync_b);

	// Pin idles high, so its synchroniser starts high
	irs_sync #(
		.W    (SW),
		.INIT (SYNC_INIT)
	) u_sync (
		.clk   (clk),
		.rst_b (rst_sync_b),
		.d     ({rst_pin_in, stage_fault, cond}),
		.q     (sync_q)
	);

	assign cond_s  = irs_pkg::irs_cond_t'(sync_q[CW-1:0]);
	assign fault_s = sync_q[CW+NSTG-1:CW];
	assign pin_s   = sync_q[SW-1];

	////////////////////////////////////////////////////////////////////////////
	// Reset causes and pin stretch

	assign ot_cause  = cond_s.overtemp && !interrupt_enable_mask[irs_pkg::BIT_OTRD];
	assign int_cause = ot_cause || cond_s.watchdog || cond_s.vdd_low;
	assign drive     = !rst_pin_oe_b;

	// Counter starts loaded so that power-on also gets a full stretch
	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			stretch_cnt <= STRETCH_LD;
		else if (int_cause)
			stretch_cnt <= STRETCH_LD;
		else if (stretch_cnt != '0)
			stretch_cnt <= stretch_cnt - 1'h1;
	end

	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			rst_pin_oe_b <= 1'h0;
			rst_pin_out  <= 1'h0;
			drive_hist   <= '1;
		end
		else
		begin
			rst_pin_oe_b <= !(int_cause || (stretch_cnt != '0));
			rst_pin_out  <= 1'h0;
			drive_hist   <= {drive_hist[irs_pkg::PIN_GUARD-2:0], drive};
		end
	end

	// Own release echoes back through the synchroniser; guard those cycles
	assign ext_low  = !pin_s && !drive && (drive_hist == '0);
	assign soft_clr = int_cause || drive || ext_low;

	// Wake source is sampled only during the power-on stretch
	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			por_phase <= 1'h1;
		else if (!drive)
			por_phase <= 1'h0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Register write decode

	assign wr_mask  = hit(req.wr, req.addr, irs_pkg::ADDR_MASK);
	assign wr_flags = hit(req.wr, req.addr, irs_pkg::ADDR_FLAGS);
	assign wr_cause = hit(req.wr, req.addr, irs_pkg::ADDR_CAUSE);

	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			interrupt_enable_mask <= irs_pkg::MASK_RESET;
		else if (soft_clr)
			interrupt_enable_mask <= irs_pkg::MASK_RESET;
		else if (wr_mask)
			interrupt_enable_mask <= req.wdata;
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt flags

	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			wake_prev <= 1'h0;
			hall_prev <= 1'h0;
			bus_prev  <= 1'h0;
		end
		else
		begin
			wake_prev <= cond_s.wake_in;
			hall_prev <= cond_s.hall_in;
			bus_prev  <= cond_s.bus_wake;
		end
	end

	always_comb
	begin
		ifr_set = 8'h00;
		ifr_set[irs_pkg::BIT_WAKE] = cond_s.wake_in ^ wake_prev;
		ifr_set[irs_pkg::BIT_HALL] = cond_s.hall_in ^ hall_prev;
		ifr_set[irs_pkg::BIT_BUS]  = cond_s.bus_wake && !bus_prev;
		ifr_set[irs_pkg::BIT_OT]   = cond_s.overtemp;
		ifr_set[irs_pkg::BIT_LOW]  = cond_s.low_supply;
		ifr_set[irs_pkg::BIT_OVER] = cond_s.over_supply;
		ifr_clr = wr_flags ? req.wdata : 8'h00;
		ifr_clr[irs_pkg::BIT_OTRD] = 1'h0;
		ifr_clr[irs_pkg::BIT_PSF]  = 1'h0;
		// A set in the same cycle outlasts the clear
		next_ifr = (ifr & ~ifr_clr) | ifr_set;
		if (soft_clr)
			next_ifr = irs_pkg::FLAGS_RESET;
	end

	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			ifr <= irs_pkg::FLAGS_RESET;
		else
			ifr <= next_ifr;
	end

	// Not writable here: cleared by clearing each stage's own fault flag, and held clear while a reset is in progress
	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			power_stage_fail_flag <= 1'h0;
		else
			power_stage_fail_flag <= !soft_clr && (|fault_s);
	end

	always_comb
	begin
		ifr_view = ifr;
		ifr_view[irs_pkg::BIT_PSF] = power_stage_fail_flag;
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt line

	// Disable bit in position four never meets a flag, flag bit four is zero
	assign pend = ifr_view & interrupt_enable_mask;

	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			pend_q <= 8'h00;
			irq_b  <= 1'h1;
		end
		else
		begin
			pend_q <= pend;
			irq_b  <= !(|(pend & ~pend_q));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Reset cause log

	always_comb
	begin
		cause_set = 8'h00;
		cause_set[irs_pkg::CAUSE_PIN]   = ext_low;
		cause_set[irs_pkg::CAUSE_WDOG]  = cond_s.watchdog;
		cause_set[irs_pkg::CAUSE_OT]    = ot_cause;
		cause_set[irs_pkg::CAUSE_LOW]   = cond_s.vdd_low;
		cause_set[irs_pkg::CAUSE_BUSWK] = por_phase && cond_s.woke_bus;
		cause_set[irs_pkg::CAUSE_INWK]  = por_phase && cond_s.woke_wake;
		cause_clr = wr_cause ? req.wdata : 8'h00;
		next_cause = (reset_cause_log & ~cause_clr) | cause_set;
	end

	// Only power-on touches this register through reset
	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			reset_cause_log <= irs_pkg::CAUSE_RESET;
		else
			reset_cause_log <= next_cause;
	end

	////////////////////////////////////////////////////////////////////////////
	// Read port

	always_ff @(posedge clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			rd_valid <= 1'h0;
			rd_data  <= 8'h00;
		end
		else
		begin
			rd_valid <= req.rd;
			if (req.rd)
			begin
				unique case (req.addr)
					irs_pkg::ADDR_MASK:  rd_data <= interrupt_enable_mask;
					irs_pkg::ADDR_FLAGS: rd_data <= ifr_view;
					irs_pkg::ADDR_CAUSE: rd_data <= reset_cause_log;
					default:             rd_data <= 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	a_low_set:
		assert property (cond_s.low_supply && !soft_clr |=> ifr[irs_pkg::BIT_LOW])
		else $error("low supply flag missed or cleared early");

	a_over_set:
		assert property (cond_s.over_supply && !soft_clr |=> ifr[irs_pkg::BIT_OVER])
		else $error("over supply flag missed or cleared early");

	a_ot_keep:
		assert property (ifr[irs_pkg::BIT_OT] && cond_s.overtemp && wr_flags && !soft_clr
			|=> ifr[irs_pkg::BIT_OT])
		else $error("overtemperature flag cleared while condition present");

	a_psf_track:
		assert property (1'h1 |=> power_stage_fail_flag == ($past(|fault_s) && !$past(soft_clr)))
		else $error("stage fail flag does not follow faults");

	a_irq_cause:
		assert property (!irq_b |-> $past(|(ifr_view & interrupt_enable_mask & ~pend_q)))
		else $error("interrupt pulse without enabled new flag");

	a_irq_pulse:
		assert property ((|(pend & ~pend_q)) |=> !irq_b)
		else $error("enabled event gave no interrupt pulse");

	a_mask_clear:
		assert property (soft_clr |=> interrupt_enable_mask == 8'h00)
		else $error("enable bits survive a reset");

	a_otrd_block:
		assert property (interrupt_enable_mask[irs_pkg::BIT_OTRD] && cond_s.overtemp
			&& !cond_s.watchdog && !cond_s.vdd_low
			|=> !reset_cause_log[irs_pkg::CAUSE_OT] || $past(reset_cause_log[irs_pkg::CAUSE_OT]))
		else $error("thermal reset logged while disabled");

	a_stretch_hold:
		assert property ($fell(int_cause) |-> !rst_pin_oe_b [*8])
		else $error("reset pin released too soon after cause");

	a_wdog_log:
		assert property (cond_s.watchdog |=> reset_cause_log[irs_pkg::CAUSE_WDOG] && !rst_pin_oe_b)
		else $error("watchdog reset not logged or pin not low");

	a_pin_log:
		assert property (ext_low |=> reset_cause_log[irs_pkg::CAUSE_PIN])
		else $error("external pin reset not logged");

	a_cause_sticky:
		assert property (!wr_cause |=> (reset_cause_log & $past(reset_cause_log)) == $past(reset_cause_log))
		else $error("cause bit lost without a write");

endmodule

`default_nettype wire

// ===== common/irs_pkg.sv
/*
 * Shared constants and carrier types of the interrupt and reset status block:
 * register offsets, bit positions, reset values and the reset stretch timing.
 * Assumes a 125 MHz device clock and an 8-bit internal register port.
 */
`default_nettype none

package irs_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] ADDR_MASK  = 8'h09;
	localparam logic [7:0] ADDR_FLAGS = 8'h0A;
	localparam logic [7:0] ADDR_CAUSE = 8'h0D;

	////////////////////////////////////////////////////////////////////////////
	// Bit positions shared by the flag and mask registers
	localparam int BIT_WAKE = 7;
	localparam int BIT_HALL = 6;
	localparam int BIT_BUS  = 5;
	localparam int BIT_OTRD = 4;
	localparam int BIT_OT   = 3;
	localparam int BIT_LOW  = 2;
	localparam int BIT_OVER = 1;
	localparam int BIT_PSF  = 0;

	// Bit positions of the reset cause log
	localparam int CAUSE_POR   = 7;
	localparam int CAUSE_PIN   = 6;
	localparam int CAUSE_WDOG  = 5;
	localparam int CAUSE_OT    = 4;
	localparam int CAUSE_LOW   = 3;
	localparam int CAUSE_BUSWK = 2;
	localparam int CAUSE_INWK  = 1;

	////////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] MASK_RESET  = 8'h00;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] CAUSE_RESET = 8'h80;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int     CLK_KHZ     = 125000;
	localparam longint T_RST_NS    = 1250000;
	localparam int     STRETCH_CYC = int'(T_RST_NS * CLK_KHZ / 1000000);
	localparam int     STRETCH_W   = 18;
	localparam int     PIN_GUARD   = 3;
	localparam int     N_STAGES    = 9;

	////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} irs_req_t;

	typedef struct packed {
		logic low_supply;
		logic over_supply;
		logic overtemp;
		logic watchdog;
		logic vdd_low;
		logic wake_in;
		logic hall_in;
		logic bus_wake;
		logic woke_bus;
		logic woke_wake;
	} irs_cond_t;

endpackage

`default_nettype wire

// ===== logic/irs_sync.sv
/*
 * Two flip-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a slow level; bits are not coherent with each other.
 */
`default_nettype none

module irs_sync #(
	parameter int             W    = 1,
	parameter logic [W-1:0]   INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta;

	// Only the second stage is visible outside
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta <= INIT;
			q    <= INIT;
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule

`default_nettype wire

// ===== bench/irs_mcu_model.sv
/*
 * Microcontroller side of the internal register port: one-cycle write
 * and read strobes launched on the falling edge.
 * Assumes the block answers a read with a registered rd_valid pulse.
 */
`default_nettype none

module irs_mcu_model (
	input  wire logic        clk,
	input  wire logic [7:0]  rd_data,
	input  wire logic        rd_valid,
	output var irs_pkg::irs_req_t req
);
	timeunit 1ns;
	timeprecision 1ps;

	initial req = '0;

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge clk);
		req = '0;
	endtask

	// Read data is taken in the cycle rd_valid stands, never later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int n;
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk);
		req = '0;
		n = 0;
		while (rd_valid !== 1'b1 && n < 4)
		begin
			@(negedge clk);
			n++;
		end
		d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
	endtask
endmodule

`default_nettype wire

// ===== bench/interrupt_and_reset_status_tb.sv
/*
 * Self-checking bench of the interrupt and reset status block.
 * Assumes a shortened reset stretch and a pulled-up open-drain reset pin.
 */
`default_nettype none

module interrupt_and_reset_status_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int STR = 16;
	localparam int NS  = irs_pkg::N_STAGES;

	logic               clk;
	logic               rst_b;
	irs_pkg::irs_req_t  req;
	irs_pkg::irs_cond_t cond;
	logic [NS-1:0]      stage_fault;
	logic               ext_low;
	logic               pin_lvl;
	logic [7:0]         rd_data;
	logic               rd_valid;
	logic               irq_b;
	logic               rst_pin_out;
	logic               rst_pin_oe_b;
	logic [7:0]         got;
	int                 fails;
	int                 comparisons;
	int                 irqs;
	int                 n;
	int                 b;
	int                 src[6]  = '{2, 1, 3, 7, 6, 5};
	int                 rcode[3] = '{10, 11, 3};
	int                 rbit[3]  = '{5, 3, 4};

	////////////////////////////////////////////////////////////////////////////
	// Open-drain pin: the pull-up wins unless either party drives low
	assign pin_lvl = (rst_pin_oe_b === 1'b0) ? rst_pin_out : !ext_low;

	irs_top #(.STRETCH(STR), .NSTG(NS)) dut_u (
		.clk(clk), .rst_b(rst_b), .req(req), .cond(cond),
		.stage_fault(stage_fault), .rst_pin_in(pin_lvl),
		.rd_data(rd_data), .rd_valid(rd_valid), .irq_b(irq_b),
		.rst_pin_out(rst_pin_out), .rst_pin_oe_b(rst_pin_oe_b));

	irs_mcu_model mcu_u (
		.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .req(req));

	initial clk = 1'b0;
	always #4 clk = ~clk;

	always @(posedge clk)
		if (irq_b === 1'b0)
			irqs++;

	////////////////////////////////////////////////////////////////////////////
	task automatic final_report;
		if (fails == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		mcu_u.rd(a, got);
		chk(got, e);
	endtask

	// n ends as the cycle count until the device lets the pin go
	task automatic wait_rel;
		n = 0;
		while (rst_pin_oe_b !== 1'b1 && n < 400)
		begin
			@(negedge clk);
			n++;
		end
		repeat (4) @(negedge clk);
	endtask

	task automatic setc(input int k, input logic v);
		case (k)
			1: cond.over_supply = v;
			2: cond.low_supply = v;
			3: cond.overtemp = v;
			5: cond.bus_wake = v;
			6: cond.hall_in = v;
			7: cond.wake_in = v;
			10: cond.watchdog = v;
			default: cond.vdd_low = v;
		endcase
	endtask

	initial
	begin
		#200000;
		fails++;
		final_report();
	end

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		rst_b = 1'b0;
		cond = '0;
		stage_fault = '0;
		ext_low = 1'b0;
		void'($urandom(32'h972A4D2B));
		repeat (10) @(negedge clk);
		rst_b = 1'b1;
		wait_rel();
		chk(8'(n >= STR), 8'h01);
		rdc(irs_pkg::ADDR_CAUSE, 8'h80);
		rdc(irs_pkg::ADDR_MASK, 8'h00);
		rdc(irs_pkg::ADDR_FLAGS, 8'h00);
		rdc(8'h0B, 8'h00);
		got = 8'($urandom);
		mcu_u.wr(irs_pkg::ADDR_MASK, got);
		mcu_u.wr(8'h0B, ~got);
		rdc(irs_pkg::ADDR_MASK, got);
		mcu_u.wr(irs_pkg::ADDR_CAUSE, 8'h7F);
		rdc(irs_pkg::ADDR_CAUSE, 8'h80);
		mcu_u.wr(irs_pkg::ADDR_CAUSE, 8'hFF);
		rdc(irs_pkg::ADDR_CAUSE, 8'h00);
		// Each flag source except the stage fail flag, with its enable set
		mcu_u.wr(irs_pkg::ADDR_MASK, 8'hFF);
		foreach (src[i])
		begin
			b = src[i];
			n = irqs;
			setc(b, 1'b1);
			repeat (6) @(negedge clk);
			chk(8'(irqs - n), 8'h01);
			rdc(irs_pkg::ADDR_FLAGS, 8'(1 << b));
			if (i < 3)
			begin
				mcu_u.wr(irs_pkg::ADDR_FLAGS, 8'(1 << b));
				rdc(irs_pkg::ADDR_FLAGS, 8'(1 << b));
			end
			setc(b, 1'b0);
			repeat (6) @(negedge clk);
			mcu_u.wr(irs_pkg::ADDR_FLAGS, 8'hFF);
			rdc(irs_pkg::ADDR_FLAGS, 8'h00);
		end
		// A masked flag stays silent until its enable is written
		mcu_u.wr(irs_pkg::ADDR_MASK, 8'h10);
		n = irqs;
		setc(2, 1'b1);
		repeat (6) @(negedge clk);
		chk(8'(irqs - n), 8'h00);
		mcu_u.wr(irs_pkg::ADDR_MASK, 8'h14);
		repeat (4) @(negedge clk);
		chk(8'(irqs - n), 8'h01);
		setc(2, 1'b0);
		repeat (6) @(negedge clk);
		mcu_u.wr(irs_pkg::ADDR_FLAGS, 8'hFF);
		// Stage fault flag follows the stage flags, not the port
		b = $urandom_range(NS - 1, 0);
		mcu_u.wr(irs_pkg::ADDR_MASK, 8'h11);
		n = irqs;
		stage_fault[b] = 1'b1;
		repeat (6) @(negedge clk);
		chk(8'(irqs - n), 8'h01);
		mcu_u.wr(irs_pkg::ADDR_FLAGS, 8'h01);
		rdc(irs_pkg::ADDR_FLAGS, 8'h01);
		stage_fault = '0;
		repeat (6) @(negedge clk);
		rdc(irs_pkg::ADDR_FLAGS, 8'h00);
		// Thermal reset disabled: no pin drive, no cause
		mcu_u.wr(irs_pkg::ADDR_MASK, 8'h10);
		setc(3, 1'b1);
		n = 0;
		repeat (8)
		begin
			@(negedge clk);
			if (rst_pin_oe_b !== 1'b1)
				n++;
		end
		chk(8'(n), 8'h00);
		setc(3, 1'b0);
		rdc(irs_pkg::ADDR_CAUSE, 8'h00);
		// Internal reset causes
		foreach (rcode[i])
		begin
			mcu_u.wr(irs_pkg::ADDR_FLAGS, 8'hFF);
			mcu_u.wr(irs_pkg::ADDR_MASK, 8'h2A);
			setc(rcode[i], 1'b1);
			repeat (4) @(negedge clk);
			setc(rcode[i], 1'b0);
			wait_rel();
			chk(8'(n >= STR && n <= STR + 8), 8'h01);
			rdc(irs_pkg::ADDR_CAUSE, 8'(1 << rbit[i]));
			rdc(irs_pkg::ADDR_MASK, 8'h00);
			mcu_u.wr(irs_pkg::ADDR_CAUSE, 8'h00);
			rdc(irs_pkg::ADDR_CAUSE, 8'(1 << rbit[i]));
			mcu_u.wr(irs_pkg::ADDR_CAUSE, 8'(1 << rbit[i]));
			rdc(irs_pkg::ADDR_CAUSE, 8'h00);
		end
		ext_low = 1'b1;
		repeat (6) @(negedge clk);
		ext_low = 1'b0;
		wait_rel();
		rdc(irs_pkg::ADDR_CAUSE, 8'h40);
		// Power-on with each wake source present
		for (int j = 0; j < 2; j++)
		begin
			cond.woke_bus = (j == 0);
			cond.woke_wake = (j == 1);
			rst_b = 1'b0;
			repeat (3) @(negedge clk);
			rst_b = 1'b1;
			wait_rel();
			cond.woke_bus = 1'b0;
			cond.woke_wake = 1'b0;
			rdc(irs_pkg::ADDR_CAUSE, (j == 0) ? 8'h84 : 8'h82);
		end
		final_report();
	end
endmodule

`default_nettype wire
